// [core/clkpd_ctrl.sv]
// Clock divider, prescaler, power-down modes and module standby with APB registers
//
// How it works
// - Duty adjustment is on when the oscillator runs at 5 MHz or more.
// - Prescaler derives phi/2 through phi/4096 ticks from the system clock.
// - Divider ratio can be rewritten at run time; phi and its pin follow.
// - Ratio field 00,01,10,11 selects divide by 1,2,4,8; resets to 1.
// - Divider register resets to fc and in hardware standby, kept in software standby.
// - Upper six divider bits ignore writes and read as ones.
// - Clock pin stop bit 7: 0 drives phi on its pin, 1 disables it.
// - Halt request enters sleep if standby select is 0, software standby if 1.
// - Sleep: clock runs, CPU halted, modules active, phi pin still outputs.
// - Software standby: clock and CPU halted, modules reset, phi pin high.
// - Standby pin low forces hardware standby: pins float, modules reset.
// - Sleep exits on interrupt; software standby on external wake; both on pins.
// - Standby select stays 1 after wake; only a software write or reset clears it.
// - Settle code selects 8192..262144 states, 110 gives 1024, 111 illegal.
// - Bus hold bit: 0 floats bus in software standby, 1 holds address, strobes high.
// - High module stop register resets to 78, also in hardware standby.
// - High register bits 6..3 read one; bit 2 is plain storage.
// - High register bits 1 and 0 stop serial channels 1 and 0.
// - Setting a stop bit halts and resets the module; software reprograms it.
// - Module stop works independently of the power-down modes.
// - Low register bits 4,3,2,0 stop timer16, timer8 pairs and converter.
// - Wake from software standby restarts clock, waits settle count, then exception.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps

module clkpd_ctrl #(
  parameter int unsigned SETTLE_STATES_0 = 8192,
  parameter int unsigned SETTLE_STATES_1 = 16384,
  parameter int unsigned SETTLE_STATES_2 = 32768,
  parameter int unsigned SETTLE_STATES_3 = 65536,
  parameter int unsigned SETTLE_STATES_4 = 131072,
  parameter int unsigned SETTLE_STATES_5 = 262144
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [21:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        HALT_REQ,
  input  wire logic        WAKE_IRQ,
  input  wire logic        WAKE_EXT,
  input  wire logic        HW_STANDBY_PIN_N,
  output logic             DUTY_ADJ_ON,
  output logic             SYS_CLK_EN,
  output logic [11:0]      PRESCALE_TICK,
  output logic             PHI_PIN_O,
  output logic             PHI_PIN_OE,
  output logic             CPU_HALT,
  output logic             CPU_REG_LOST,
  output logic             WAKE_EXCEPTION,
  output logic             SERIAL0_STOP,
  output logic             SERIAL1_STOP,
  output logic             TIMER16_STOP,
  output logic             TIMER8_CH01_STOP,
  output logic             TIMER8_CH23_STOP,
  output logic             CONVERTER_STOP,
  output logic             PORT_HIZ,
  output logic             ADDR_BUS_OE,
  output logic             ADDR_FREEZE,
  output logic             CTRL_BUS_OE,
  output logic             CTRL_FORCE_HIGH,
  output logic             ONCHIP_RAM_ENABLE
);

  typedef struct packed {
    clkpd_pkg::mode_t               mode;
    logic [7:0]                     pmc;
    logic [1:0]                     divc;
    logic [7:0]                     msth;
    logic [7:0]                     mstl;
    logic [1:0]                     ratio;
    logic [2:0]                     div_cnt;
    logic [11:0]                    pre;
    logic [clkpd_pkg::SETTLE_W-1:0] settle_cnt;
    logic [clkpd_pkg::SETTLE_W-1:0] settle_lim;
    logic                           sys_en;
    logic [11:0]                    pre_tick;
    logic                           phi_o;
    logic                           phi_oe;
    logic                           cpu_halt;
    logic                           cpu_lost;
    logic                           wake_exc;
    logic [5:0]                     mod_stop;
    logic                           port_hiz;
    logic                           addr_oe;
    logic                           addr_frz;
    logic                           ctrl_oe;
    logic                           ctrl_high;
    logic                           duty_adj;
    logic                           pready;
    logic                           pslverr;
    logic [7:0]                     prdata;
  } state_t;

  state_t st;
  state_t next_st;

  logic [11:0] pre_hit;
  logic [19:0] idx;
  logic        word_ok;

  assign idx     = PADDR[21:2];
  assign word_ok = (PADDR[1:0] == 2'b00);

  // Prescaler tap k fires when the low k+1 bits are all ones
  genvar k;
  generate
    for (k = 0; k < clkpd_pkg::PRESCALE_TAPS; k = k + 1) begin : g_tap
      assign pre_hit[k] = &st.pre[k:0];
    end
  endgenerate

  // Settle length for a code; illegal code takes the longest wait
  function automatic logic [clkpd_pkg::SETTLE_W-1:0] settle_states(input logic [2:0] code);
    logic [clkpd_pkg::SETTLE_W-1:0] n;
    n = clkpd_pkg::SETTLE_W'(SETTLE_STATES_5);
    case (code)
      3'h0: n = clkpd_pkg::SETTLE_W'(SETTLE_STATES_0);
      3'h1: n = clkpd_pkg::SETTLE_W'(SETTLE_STATES_1);
      3'h2: n = clkpd_pkg::SETTLE_W'(SETTLE_STATES_2);
      3'h3: n = clkpd_pkg::SETTLE_W'(SETTLE_STATES_3);
      3'h4: n = clkpd_pkg::SETTLE_W'(SETTLE_STATES_4);
      3'h5: n = clkpd_pkg::SETTLE_W'(SETTLE_STATES_5);
      3'h6: n = clkpd_pkg::SETTLE_W'(clkpd_pkg::SETTLE_STATES_SHORT);
      default: n = clkpd_pkg::SETTLE_W'(SETTLE_STATES_5);
    endcase
    return n;
  endfunction

  // Last divider count of one phi period for a ratio code
  function automatic logic [2:0] div_last(input logic [1:0] r);
    logic [2:0] m;
    m = 3'h0;
    case (r)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      default: m = 3'h7;
    endcase
    return m;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic       running;
    logic       tick;
    logic       wr;
    logic       rd_done;
    logic       hit;
    logic [7:0] rdata;
    logic       in_sw;
    logic       in_hw;
    running = 1'b0;
    tick    = 1'b0;
    wr      = 1'b0;
    rd_done = 1'b0;
    hit     = 1'b1;
    rdata   = 8'h00;
    in_sw   = 1'b0;
    in_hw   = 1'b0;
    next_st = st;

    // Oscillator is always 25 MHz here, so duty adjustment stays on
    next_st.duty_adj = (clkpd_pkg::OSC_HZ >= clkpd_pkg::DUTY_ADJ_MIN_HZ);

    // Divider runs while the oscillator runs: run, sleep and settling
    running = (st.mode == clkpd_pkg::MODE_RUN) || (st.mode == clkpd_pkg::MODE_SLEEP) ||
              (st.mode == clkpd_pkg::MODE_SETTLE);
    tick = running && (st.div_cnt == div_last(st.ratio));
    if (running) begin
      next_st.div_cnt = tick ? 3'h0 : st.div_cnt + 3'h1;
    end
    // Ratio switches at a period boundary, or at once while the divider is stopped, avoiding runt phases
    if (tick || !running) begin
      next_st.ratio = st.divc;
    end
    next_st.sys_en = tick;

    // Phi pin waveform: high in the first half of each period; at divide by 1 it toggles every cycle
    if (st.ratio == 2'h0) begin
      next_st.phi_o = running ? ~st.phi_o : 1'b1;
    end else begin
      next_st.phi_o = running ? (next_st.div_cnt <= (div_last(st.ratio) >> 1)) : 1'b1;
    end
    // Prescaler; reset with the modules in either standby
    for (int i = 0; i < clkpd_pkg::PRESCALE_TAPS; i++) begin
      next_st.pre_tick[i] = tick && pre_hit[i];
    end
    if (tick) begin
      next_st.pre = st.pre + 12'h001;
    end

    // APB slave: one wait state, write and read data at the ready edge
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    if (PSEL && PENABLE && !st.pready) begin
      next_st.pready = 1'b1;
      hit = word_ok;
      if (idx == clkpd_pkg::IDX_POWER_MODE_CONTROL) begin
        rdata = st.pmc;
      end else if (idx == clkpd_pkg::IDX_CLOCK_DIVIDE_CONTROL) begin
        rdata = clkpd_pkg::DIVC_FIXED_ONES | {6'h00, st.divc};
      end else if (idx == clkpd_pkg::IDX_MODULE_STOP_HIGH) begin
        rdata = st.msth | clkpd_pkg::MSTH_FIXED_ONES;
      end else if (idx == clkpd_pkg::IDX_MODULE_STOP_LOW) begin
        rdata = st.mstl;
      end else if (idx == clkpd_pkg::IDX_POWER_STATE) begin
        rdata = {5'h00, st.mode};
      end else begin
        hit = 1'b0;
      end
      if (!word_ok) begin
        hit = 1'b0;
      end
      next_st.pslverr = !hit;
      next_st.prdata  = hit ? rdata : 8'h00;
    end
    wr      = PSEL && PENABLE && st.pready && PWRITE && !st.pslverr;
    rd_done = PSEL && PENABLE && st.pready;
    if (wr) begin
      if (idx == clkpd_pkg::IDX_POWER_MODE_CONTROL) begin
        next_st.pmc = PWDATA[7:0];
      end else if (idx == clkpd_pkg::IDX_CLOCK_DIVIDE_CONTROL) begin
        next_st.divc = PWDATA[1:0];
      end else if (idx == clkpd_pkg::IDX_MODULE_STOP_HIGH) begin
        next_st.msth = PWDATA[7:0] & ~clkpd_pkg::MSTH_FIXED_ONES;
      end else if (idx == clkpd_pkg::IDX_MODULE_STOP_LOW) begin
        next_st.mstl = PWDATA[7:0];
      end
    end
    if (!rd_done && !(PSEL && PENABLE)) begin
      next_st.prdata = st.prdata;
    end

    // Power-down state machine; the standby pin beats everything but reset
    next_st.wake_exc = 1'b0;
    case (st.mode)
      clkpd_pkg::MODE_RUN: begin
        if (HALT_REQ) begin
          next_st.mode = st.pmc[clkpd_pkg::POS_STANDBY_SELECT] ?
                         clkpd_pkg::MODE_SW_STANDBY : clkpd_pkg::MODE_SLEEP;
        end
      end
      clkpd_pkg::MODE_SLEEP: begin
        if (WAKE_IRQ || WAKE_EXT) begin
          next_st.mode     = clkpd_pkg::MODE_RUN;
          next_st.wake_exc = 1'b1;
        end
      end
      clkpd_pkg::MODE_SW_STANDBY: begin
        // Only external wake sources restart the oscillator
        if (WAKE_EXT) begin
          next_st.mode       = clkpd_pkg::MODE_SETTLE;
          next_st.settle_cnt = '0;
          next_st.settle_lim = settle_states(st.pmc[clkpd_pkg::POS_SETTLE_SEL_2:
                                                    clkpd_pkg::POS_SETTLE_SEL_0]);
        end
      end
      clkpd_pkg::MODE_SETTLE: begin
        // Count divided phi states, so a larger ratio waits longer
        if (tick) begin
          next_st.settle_cnt = st.settle_cnt + 1'b1;
          if (st.settle_cnt == st.settle_lim - 1'b1) begin
            next_st.mode     = clkpd_pkg::MODE_RUN;
            next_st.wake_exc = 1'b1;
          end
        end
      end
      clkpd_pkg::MODE_HW_STANDBY: begin
        // Left only through reset
        next_st.mode = clkpd_pkg::MODE_HW_STANDBY;
      end
      default: begin
        next_st.mode = clkpd_pkg::MODE_RUN;
      end
    endcase
    if (!HW_STANDBY_PIN_N) begin
      next_st.mode     = clkpd_pkg::MODE_HW_STANDBY;
      next_st.wake_exc = 1'b0;
    end

    // Hardware standby reinitialises divider and module stop registers
    if (next_st.mode == clkpd_pkg::MODE_HW_STANDBY) begin
      next_st.divc = clkpd_pkg::RST_CLOCK_DIVIDE_CONTROL[1:0];
      next_st.msth = clkpd_pkg::RST_MODULE_STOP_HIGH & ~clkpd_pkg::MSTH_FIXED_ONES;
      next_st.mstl = clkpd_pkg::RST_MODULE_STOP_LOW;
    end

    in_sw = (next_st.mode == clkpd_pkg::MODE_SW_STANDBY) ||
            (next_st.mode == clkpd_pkg::MODE_SETTLE);
    in_hw = (next_st.mode == clkpd_pkg::MODE_HW_STANDBY);
    // Phi pin held high through standby and the settling wait, in step with the mode
    if (in_sw) begin
      next_st.phi_o = 1'b1;
    end
    if (in_sw || in_hw) begin
      next_st.pre      = 12'h000;
      next_st.pre_tick = 12'h000;
    end
    if (in_hw) begin
      next_st.div_cnt = 3'h0;
      next_st.sys_en  = 1'b0;
    end

    // Pin and core controls follow the next mode
    next_st.cpu_halt = (next_st.mode != clkpd_pkg::MODE_RUN);
    next_st.cpu_lost = in_hw;
    next_st.port_hiz = in_hw;
    next_st.phi_oe   = !in_hw && !next_st.msth[clkpd_pkg::POS_CLOCK_PIN_STOP];
    next_st.addr_frz = in_sw;
    next_st.addr_oe  = !in_hw && !(in_sw && !st.pmc[clkpd_pkg::POS_STANDBY_BUS_HOLD]);
    next_st.ctrl_oe  = next_st.addr_oe;
    next_st.ctrl_high = in_sw && st.pmc[clkpd_pkg::POS_STANDBY_BUS_HOLD];

    // Stop bits halt modules regardless of mode; standby halts all
    next_st.mod_stop = {next_st.msth[clkpd_pkg::POS_SERIAL1_STOP],
                        next_st.msth[clkpd_pkg::POS_SERIAL0_STOP],
                        next_st.mstl[clkpd_pkg::POS_TIMER16_STOP],
                        next_st.mstl[clkpd_pkg::POS_TIMER8_CH01_STOP],
                        next_st.mstl[clkpd_pkg::POS_TIMER8_CH23_STOP],
                        next_st.mstl[clkpd_pkg::POS_CONVERTER_STOP]} |
                       {6{in_sw || in_hw}};
  end

  // State register; synchronous reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      st          <= '0;
      st.mode     <= clkpd_pkg::MODE_RUN;
      st.pmc      <= clkpd_pkg::RST_POWER_MODE_CONTROL;
      st.divc     <= clkpd_pkg::RST_CLOCK_DIVIDE_CONTROL[1:0];
      st.msth     <= clkpd_pkg::RST_MODULE_STOP_HIGH & ~clkpd_pkg::MSTH_FIXED_ONES;
      st.mstl     <= clkpd_pkg::RST_MODULE_STOP_LOW;
      st.phi_oe   <= 1'b1;
      st.addr_oe  <= 1'b1;
      st.ctrl_oe  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Ports straight from the state flops
  assign PRDATA            = {24'h000000, st.prdata};
  assign PREADY            = st.pready;
  assign PSLVERR           = st.pslverr;
  assign DUTY_ADJ_ON       = st.duty_adj;
  assign SYS_CLK_EN        = st.sys_en;
  assign PRESCALE_TICK     = st.pre_tick;
  assign PHI_PIN_O         = st.phi_o;
  assign PHI_PIN_OE        = st.phi_oe;
  assign CPU_HALT          = st.cpu_halt;
  assign CPU_REG_LOST      = st.cpu_lost;
  assign WAKE_EXCEPTION    = st.wake_exc;
  assign SERIAL1_STOP      = st.mod_stop[5];
  assign SERIAL0_STOP      = st.mod_stop[4];
  assign TIMER16_STOP      = st.mod_stop[3];
  assign TIMER8_CH01_STOP  = st.mod_stop[2];
  assign TIMER8_CH23_STOP  = st.mod_stop[1];
  assign CONVERTER_STOP    = st.mod_stop[0];
  assign PORT_HIZ          = st.port_hiz;
  assign ADDR_BUS_OE       = st.addr_oe;
  assign ADDR_FREEZE       = st.addr_frz;
  assign CTRL_BUS_OE       = st.ctrl_oe;
  assign CTRL_FORCE_HIGH   = st.ctrl_high;
  assign ONCHIP_RAM_ENABLE = st.pmc[clkpd_pkg::POS_ONCHIP_RAM_EN];

endmodule

// [pkg/clkpd_pkg.sv]
// Constants and types shared by the clock divider and power-down controller
package clkpd_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [19:0] IDX_POWER_MODE_CONTROL   = 20'hee012;
  localparam logic [19:0] IDX_CLOCK_DIVIDE_CONTROL = 20'hee01b;
  localparam logic [19:0] IDX_MODULE_STOP_HIGH     = 20'hee01c;
  localparam logic [19:0] IDX_MODULE_STOP_LOW      = 20'hee01d;
  localparam logic [19:0] IDX_POWER_STATE          = 20'hee01e;

  // Values after reset
  localparam logic [7:0] RST_POWER_MODE_CONTROL   = 8'h09;
  localparam logic [7:0] RST_CLOCK_DIVIDE_CONTROL = 8'hfc;
  localparam logic [7:0] RST_MODULE_STOP_HIGH     = 8'h78;
  localparam logic [7:0] RST_MODULE_STOP_LOW      = 8'h00;

  // Fixed read-as-one masks
  localparam logic [7:0] DIVC_FIXED_ONES = 8'hfc;
  localparam logic [7:0] MSTH_FIXED_ONES = 8'h78;

  // Field positions in power_mode_control
  localparam int POS_STANDBY_SELECT   = 7;
  localparam int POS_SETTLE_SEL_2     = 6;
  localparam int POS_SETTLE_SEL_0     = 4;
  localparam int POS_STANDBY_BUS_HOLD = 1;
  localparam int POS_ONCHIP_RAM_EN    = 0;

  // Field positions in module_stop_high
  localparam int POS_CLOCK_PIN_STOP   = 7;
  localparam int POS_SERIAL1_STOP     = 1;
  localparam int POS_SERIAL0_STOP     = 0;

  // Field positions in module_stop_low
  localparam int POS_TIMER16_STOP     = 4;
  localparam int POS_TIMER8_CH01_STOP = 3;
  localparam int POS_TIMER8_CH23_STOP = 2;
  localparam int POS_CONVERTER_STOP   = 0;

  // Oscillator and duty adjustment threshold
  localparam int unsigned OSC_HZ          = 25_000_000;
  localparam int unsigned DUTY_ADJ_MIN_HZ = 5_000_000;

  // Prescaler taps, phi/2 up to phi/4096
  localparam int PRESCALE_TAPS = 12;

  // Settling-time figures in states
  localparam int unsigned SETTLE_STATES_SHORT = 1024;
  localparam int          SETTLE_W            = 19;

  // Power-down state of the chip
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_SW_STANDBY,
    MODE_SETTLE,
    MODE_HW_STANDBY
  } mode_t;

endpackage

// [test/clkpd_ctrl_asserts.sv]
// Concurrent checks on the ports of the clock and power-down controller
`timescale 1ns/10ps

module clkpd_ctrl_asserts (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [31:0] PRDATA,
  input wire logic        HALT_REQ,
  input wire logic        HW_STANDBY_PIN_N,
  input wire logic        SYS_CLK_EN,
  input wire logic [11:0] PRESCALE_TICK,
  input wire logic        PHI_PIN_O,
  input wire logic        PHI_PIN_OE,
  input wire logic        CPU_HALT,
  input wire logic        CPU_REG_LOST,
  input wire logic        WAKE_EXCEPTION,
  input wire logic        SERIAL0_STOP,
  input wire logic        PORT_HIZ,
  input wire logic        ADDR_FREEZE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // One wait state, then the answer
  apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no ready after the wait state");
  // Refused access returns zero data
  apb_refuse_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response without ready or with data");
  // Prescaler taps only on a system clock state
  prescale_tap_a: assert property (|PRESCALE_TICK |-> SYS_CLK_EN)
    else $error("prescaler tick off the system clock");
  // Halt request in run mode stops the CPU next cycle
  halt_entry_a: assert property (HALT_REQ && !CPU_HALT && HW_STANDBY_PIN_N |=> CPU_HALT)
    else $error("halt request not taken");
  // Leaving a power-down mode raises the wake exception
  wake_exc_a: assert property ($fell(CPU_HALT) |-> WAKE_EXCEPTION)
    else $error("resume without wake exception");
  // Wake exception is a single cycle
  wake_pulse_a: assert property (WAKE_EXCEPTION |=> !WAKE_EXCEPTION)
    else $error("wake exception longer than one cycle");
  // Software standby: phi pin high, modules held, CPU halted
  sw_standby_a: assert property (ADDR_FREEZE |-> PHI_PIN_O && SERIAL0_STOP && CPU_HALT)
    else $error("software standby outputs wrong");
  // Standby pin low forces hardware standby
  hw_standby_a: assert property (!HW_STANDBY_PIN_N |-> ##[1:2]
    (PORT_HIZ && CPU_REG_LOST && !PHI_PIN_OE))
    else $error("hardware standby not entered");
  // Hardware standby only left through reset
  hw_hold_a: assert property (PORT_HIZ |=> PORT_HIZ)
    else $error("hardware standby left without reset");
endmodule

// [test/test_clkpd_ctrl.sv]
// Self-checking bench for the clock and power-down controller
`timescale 1ns/10ps

module test_clkpd_ctrl;
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, HALT_REQ = 0;
  logic WAKE_IRQ = 0, WAKE_EXT = 0, HW_STANDBY_PIN_N = 1;
  logic [21:0] PADDR = 22'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, DUTY_ADJ_ON, SYS_CLK_EN, PHI_PIN_O, PHI_PIN_OE, CPU_HALT;
  logic CPU_REG_LOST, WAKE_EXCEPTION, SERIAL0_STOP, SERIAL1_STOP, TIMER16_STOP;
  logic TIMER8_CH01_STOP, TIMER8_CH23_STOP, CONVERTER_STOP, PORT_HIZ, ADDR_BUS_OE;
  logic ADDR_FREEZE, CTRL_BUS_OE, CTRL_FORCE_HIGH, ONCHIP_RAM_ENABLE;
  logic [11:0] PRESCALE_TICK;
  logic [9:0] notes[$];
  logic [9:0] nt;
  logic [31:0] rnd = 32'h28aa;
  int mismatches = 0, n_checks = 0, p, cnt, ex;
  int settle[7] = '{8192, 32, 64, 128, 256, 512, 1024};

  // Codes 000 and 110 keep their full length; 001 to 101 are shortened to save run time
  clkpd_ctrl #(.SETTLE_STATES_1(32), .SETTLE_STATES_2(64),
    .SETTLE_STATES_3(128), .SETTLE_STATES_4(256), .SETTLE_STATES_5(512)) DUT (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .HALT_REQ(HALT_REQ), .WAKE_IRQ(WAKE_IRQ), .WAKE_EXT(WAKE_EXT),
    .HW_STANDBY_PIN_N(HW_STANDBY_PIN_N), .DUTY_ADJ_ON(DUTY_ADJ_ON),
    .SYS_CLK_EN(SYS_CLK_EN), .PRESCALE_TICK(PRESCALE_TICK), .PHI_PIN_O(PHI_PIN_O),
    .PHI_PIN_OE(PHI_PIN_OE), .CPU_HALT(CPU_HALT), .CPU_REG_LOST(CPU_REG_LOST),
    .WAKE_EXCEPTION(WAKE_EXCEPTION), .SERIAL0_STOP(SERIAL0_STOP),
    .SERIAL1_STOP(SERIAL1_STOP), .TIMER16_STOP(TIMER16_STOP),
    .TIMER8_CH01_STOP(TIMER8_CH01_STOP), .TIMER8_CH23_STOP(TIMER8_CH23_STOP),
    .CONVERTER_STOP(CONVERTER_STOP), .PORT_HIZ(PORT_HIZ), .ADDR_BUS_OE(ADDR_BUS_OE),
    .ADDR_FREEZE(ADDR_FREEZE), .CTRL_BUS_OE(CTRL_BUS_OE),
    .CTRL_FORCE_HIGH(CTRL_FORCE_HIGH), .ONCHIP_RAM_ENABLE(ONCHIP_RAM_ENABLE));

  // 25 MHz clock
  always #20 CLK = ~CLK;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; request held until ready is sampled
  task automatic bus(input logic w, input logic [19:0] idx, input logic [7:0] d,
                     input logic [8:0] e);
    @(posedge CLK);
    notes.push_back({~w, e});
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [19:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 9'h000);
  endtask

  task automatic rd(input logic [19:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, {1'b0, e});
  endtask

  task automatic pulse_halt;
    @(posedge CLK) HALT_REQ <= 1'b1;
    @(posedge CLK) HALT_REQ <= 1'b0;
  endtask

  // Cycles between two system clock states
  task automatic per(output int q);
    q = 0;
    do @(negedge CLK); while (SYS_CLK_EN !== 1'b1);
    do begin @(negedge CLK); q++; end while (SYS_CLK_EN !== 1'b1 && q < 40);
  endtask

  // Answer watcher: compare each completed transfer with the oldest note
  always @(posedge CLK)
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      nt = notes.pop_front();
      chk({PSLVERR, nt[9] ? PRDATA[7:0] : 8'h00}, nt[8:0]);
    end

  // Hang guard
  initial begin
    #(40 * 60000);
    mismatches++;
    test_done;
  end

  initial begin
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    rd(clkpd_pkg::IDX_POWER_MODE_CONTROL, 8'h09);
    rd(clkpd_pkg::IDX_CLOCK_DIVIDE_CONTROL, 8'hfc);
    rd(clkpd_pkg::IDX_MODULE_STOP_HIGH, 8'h78);
    rd(clkpd_pkg::IDX_MODULE_STOP_LOW, 8'h00);
    bus(1'b0, 20'h00001, 8'h00, 9'h100);
    chk(DUTY_ADJ_ON, 1'b1);
    // Every ratio code, period measured on the system clock enable
    for (int r = 3; r >= 0; r--) begin
      wr(clkpd_pkg::IDX_CLOCK_DIVIDE_CONTROL, r[7:0] | 8'h50);
      rd(clkpd_pkg::IDX_CLOCK_DIVIDE_CONTROL, 8'hfc | r[7:0]);
      per(p);
      per(p);
      chk(p, 16'd1 << r);
    end
    // Random stop patterns
    repeat (4) begin
      rnd = xs(rnd);
      wr(clkpd_pkg::IDX_MODULE_STOP_LOW, rnd[7:0]);
      rd(clkpd_pkg::IDX_MODULE_STOP_LOW, rnd[7:0]);
      wr(clkpd_pkg::IDX_MODULE_STOP_HIGH, rnd[15:8]);
      rd(clkpd_pkg::IDX_MODULE_STOP_HIGH, (rnd[15:8] & 8'h87) | 8'h78);
      @(negedge CLK);
      chk({TIMER16_STOP, TIMER8_CH01_STOP, TIMER8_CH23_STOP, CONVERTER_STOP},
          {rnd[4], rnd[3], rnd[2], rnd[0]});
      chk({PHI_PIN_OE, SERIAL1_STOP, SERIAL0_STOP}, {~rnd[15], rnd[9], rnd[8]});
    end
    wr(clkpd_pkg::IDX_MODULE_STOP_LOW, 8'h00);
    // Sleep with one serial channel stopped
    wr(clkpd_pkg::IDX_MODULE_STOP_HIGH, 8'h01);
    wr(clkpd_pkg::IDX_POWER_MODE_CONTROL, 8'h01);
    pulse_halt;
    rd(clkpd_pkg::IDX_POWER_STATE, 8'h01);
    @(negedge CLK);
    chk({SERIAL0_STOP, SERIAL1_STOP, PHI_PIN_OE, CPU_HALT}, 4'b1011);
    @(posedge CLK) WAKE_IRQ <= 1'b1;
    @(posedge CLK) WAKE_IRQ <= 1'b0;
    rd(clkpd_pkg::IDX_POWER_STATE, 8'h00);
    wr(clkpd_pkg::IDX_MODULE_STOP_HIGH, 8'h00);
    // Software standby for settle codes 000 to 110, at two ratios
    for (int r = 0; r < 2; r++)
      for (int c = 0; c < 7; c++) begin
        wr(clkpd_pkg::IDX_CLOCK_DIVIDE_CONTROL, r[7:0]);
        wr(clkpd_pkg::IDX_POWER_MODE_CONTROL, 8'h81 | (c[7:0] << 4) | {6'h0, c[0], 1'b0});
        pulse_halt;
        @(posedge CLK) WAKE_IRQ <= 1'b1;
        @(posedge CLK) WAKE_IRQ <= 1'b0;
        rd(clkpd_pkg::IDX_POWER_STATE, 8'h02);
        @(negedge CLK);
        chk({ADDR_BUS_OE, CTRL_BUS_OE, CTRL_FORCE_HIGH}, {c[0], c[0], c[0]});
        chk({PHI_PIN_O, SERIAL0_STOP, CPU_HALT, ADDR_FREEZE}, 4'b1111);
        @(posedge CLK) WAKE_EXT <= 1'b1;
        @(posedge CLK) WAKE_EXT <= 1'b0;
        ex = settle[c] << r;
        cnt = 1;
        while (WAKE_EXCEPTION !== 1'b1 && cnt < 20000) begin @(negedge CLK); cnt++; end
        chk(cnt >= ex - 2 && cnt <= ex + 4, 1'b1);
        rd(clkpd_pkg::IDX_POWER_MODE_CONTROL, 8'h81 | (c[7:0] << 4) | {6'h0, c[0], 1'b0});
        rd(clkpd_pkg::IDX_CLOCK_DIVIDE_CONTROL, 8'hfc | r[7:0]);
      end
    // Hardware standby clears the divider and stop registers
    wr(clkpd_pkg::IDX_CLOCK_DIVIDE_CONTROL, 8'h03);
    wr(clkpd_pkg::IDX_MODULE_STOP_HIGH, 8'h07);
    wr(clkpd_pkg::IDX_MODULE_STOP_LOW, 8'h1d);
    wr(clkpd_pkg::IDX_POWER_MODE_CONTROL, 8'h80);
    @(posedge CLK) HW_STANDBY_PIN_N <= 1'b0;
    repeat (3) @(negedge CLK);
    chk({PORT_HIZ, CPU_REG_LOST, PHI_PIN_OE, SERIAL0_STOP, ONCHIP_RAM_ENABLE}, 5'b11010);
    rd(clkpd_pkg::IDX_POWER_STATE, 8'h04);
    rd(clkpd_pkg::IDX_CLOCK_DIVIDE_CONTROL, 8'hfc);
    rd(clkpd_pkg::IDX_MODULE_STOP_HIGH, 8'h78);
    rd(clkpd_pkg::IDX_MODULE_STOP_LOW, 8'h00);
    @(posedge CLK) HW_STANDBY_PIN_N <= 1'b1;
    RST <= 1'b1;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    rd(clkpd_pkg::IDX_POWER_STATE, 8'h00);
    repeat (4) @(posedge CLK);
    test_done;
  end
endmodule

bind clkpd_ctrl clkpd_ctrl_asserts chk_u (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
  .HALT_REQ(HALT_REQ), .HW_STANDBY_PIN_N(HW_STANDBY_PIN_N), .SYS_CLK_EN(SYS_CLK_EN),
  .PRESCALE_TICK(PRESCALE_TICK), .PHI_PIN_O(PHI_PIN_O), .PHI_PIN_OE(PHI_PIN_OE),
  .CPU_HALT(CPU_HALT), .CPU_REG_LOST(CPU_REG_LOST), .WAKE_EXCEPTION(WAKE_EXCEPTION),
  .SERIAL0_STOP(SERIAL0_STOP), .PORT_HIZ(PORT_HIZ), .ADDR_FREEZE(ADDR_FREEZE));
